// ### verilog/sclp_pkg.sv
// shared constants, command tree and types for the serial command line parser
`default_nettype none
package sclp_pkg;
	localparam int          SCLP_KW_MAX       = 10;
	localparam logic [3:0]  SCLP_KW_CAP       = 4'(SCLP_KW_MAX);
	localparam int          SCLP_NODES        = 8;
	localparam logic [2:0]  SCLP_ROOT         = 3'h0;
	localparam logic [1:0]  SCLP_CHAN_DEFAULT = 2'h1;
	localparam logic [1:0]  SCLP_CHAN_OTHER   = 2'h2;
	localparam logic [3:0]  SCLP_COMMON_MIN   = 4'h4;
	localparam logic [3:0]  SCLP_COMMON_MAX   = 4'h5;
	localparam logic [7:0]  SCLP_CR           = 8'h0D;
	localparam logic [7:0]  SCLP_LF           = 8'h0A;
	localparam logic [7:0]  SCLP_SPACE        = 8'h20;
	localparam logic [7:0]  SCLP_COLON        = 8'h3A;
	localparam logic [7:0]  SCLP_SEMI         = 8'h3B;
	localparam logic [7:0]  SCLP_QUERY        = 8'h3F;
	localparam logic [7:0]  SCLP_STAR         = 8'h2A;
	localparam logic [7:0]  SCLP_DIGIT1       = 8'h31;
	localparam logic [7:0]  SCLP_DIGIT2       = 8'h32;
	localparam logic [7:0]  SCLP_ERR_NONE     = 8'h00;
	localparam logic [7:0]  SCLP_ERR_SYNTAX   = 8'h66;
	localparam logic [7:0]  SCLP_ERR_HEADER   = 8'h71;
	localparam logic [2:0]  SCLP_PROMPT_LAST  = 3'h6;
	localparam logic [2:0]  SCLP_RESP_LAST    = 3'h3;
	localparam logic [6:0][7:0] SCLP_PROMPT   = 56'h7363_7069_203E_20;

	typedef logic [SCLP_KW_MAX-1:0][7:0] sclp_kw_t;

	typedef struct packed {
		sclp_kw_t   text;
		logic [3:0] short_len;
		logic [3:0] full_len;
		logic [2:0] parent;
		logic       implied;
		logic       chan_ok;
	} sclp_node_t;

	// node 2 is the timekeeping_node, 4 the reference_oscillator_node, 5 the oscillator_frequency_leaf
	localparam sclp_node_t SCLP_TREE [SCLP_NODES] = '{
		'{80'h0000_0000_0000_0000_0000, 4'h0, 4'h0, 3'h0, 1'b0, 1'b0},
		'{80'h534F_5552_4345_0000_0000, 4'h4, 4'h6, 3'h0, 1'b1, 1'b0},
		'{80'h434C_4F43_4B00_0000_0000, 4'h4, 4'h5, 3'h1, 1'b0, 1'b0},
		'{80'h5449_4D45_0000_0000_0000, 4'h4, 4'h4, 3'h2, 1'b1, 1'b0},
		'{80'h4F53_4349_4C4C_4154_4F52, 4'h3, 4'hA, 3'h1, 1'b0, 1'b0},
		'{80'h5241_5445_0000_0000_0000, 4'h4, 4'h4, 3'h4, 1'b0, 1'b1},
		'{80'h4449_4147_4E4F_5354_4943, 4'h4, 4'hA, 3'h0, 1'b0, 1'b0},
		'{80'h4C4F_4700_0000_0000_0000, 4'h3, 4'h3, 3'h6, 1'b0, 1'b0}
	};

	typedef struct packed {
		logic            common;
		logic            query;
		logic [2:0]      node;
		logic [1:0]      chan;
		logic [3:0][7:0] code;
	} sclp_cmd_t;

	typedef enum logic [2:0] {
		SCLP_ST_IDLE  = 3'b000,
		SCLP_ST_HDR   = 3'b001,
		SCLP_ST_PARAM = 3'b010,
		SCLP_ST_SKIP  = 3'b011,
		SCLP_ST_TX    = 3'b100
	} sclp_state_t;

	function automatic logic sclp_is_lower(input logic [7:0] c);
		return (c >= 8'h61) && (c <= 8'h7A);
	endfunction

	function automatic logic sclp_is_alpha(input logic [7:0] c);
		return sclp_is_lower(c) || ((c >= 8'h41) && (c <= 8'h5A));
	endfunction

	function automatic logic [7:0] sclp_to_upper(input logic [7:0] c);
		return sclp_is_lower(c) ? (c - 8'h20) : c;
	endfunction

	function automatic logic [7:0] sclp_hex(input logic [3:0] n);
		return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction
endpackage
`default_nettype wire

// ### verilog/sclp_kw_match.sv
// keyword lookup against the command tree, with implied levels
`default_nettype none
module sclp_kw_match
	import sclp_pkg::*;
(
	input  wire sclp_kw_t   kw_in,
	input  wire logic [3:0] len_in,
	input  wire logic [2:0] level_in,
	output logic            hit_out,
	output logic [2:0]      node_out,
	output logic [2:0]      leaf_out,
	output logic            chan_ok_out
);
	function automatic logic name_eq(input sclp_node_t n, input sclp_kw_t kw, input logic [3:0] len);
		logic eq;
		eq = ((len == n.short_len) || (len == n.full_len)) && (len != 4'h0);
		for (int p = 0; p < SCLP_KW_MAX; p++)
		begin
			if ((p < int'(len)) && (kw[SCLP_KW_MAX-1-p] != n.text[SCLP_KW_MAX-1-p]))
				eq = 1'b0;
		end
		return eq;
	endfunction

	function automatic logic under_level(input sclp_node_t n, input logic [2:0] level);
		return (n.parent == level) ||
			((n.parent != SCLP_ROOT) && SCLP_TREE[n.parent].implied && (SCLP_TREE[n.parent].parent == level));
	endfunction

	always_comb
	begin
		hit_out  = 1'b0;
		node_out = SCLP_ROOT;
		for (int i = SCLP_NODES-1; i >= 1; i--)
		begin
			if (name_eq(SCLP_TREE[i], kw_in, len_in) && under_level(SCLP_TREE[i], level_in))
			begin
				hit_out  = 1'b1;
				node_out = 3'(i);
			end
		end
		leaf_out = node_out;
		for (int j = SCLP_NODES-1; j >= 1; j--)
		begin
			if (hit_out && SCLP_TREE[j].implied && (SCLP_TREE[j].parent == node_out))
				leaf_out = 3'(j);
		end
		chan_ok_out = SCLP_TREE[node_out].chan_ok;
	end
endmodule
`default_nettype wire

// ### verilog/sclp_parser.sv
// serial command line parser: headers, parameters, prompt and query replies
`default_nettype none
module sclp_parser
	import sclp_pkg::*;
(
	input  wire logic      core_clk_in,
	input  wire logic      rst_b_in,
	input  wire logic [7:0] rx_char_in,
	input  wire logic      rx_valid_in,
	output logic           rx_ready_out,
	output logic [7:0]     tx_char_out,
	output logic           tx_valid_out,
	input  wire logic      tx_ready_in,
	output sclp_cmd_t      cmd_out,
	output logic           cmd_valid_out,
	output logic [7:0]     param_char_out,
	output logic           param_valid_out,
	input  wire logic [7:0] resp_value_in,
	output logic [7:0]     err_code_out,
	input  wire logic      err_clear_in
);
	sclp_state_t state_q, state_d;
	sclp_kw_t    kw_q, kw_d;
	logic [3:0]  len_q, len_d;
	logic [2:0]  level_q, level_d;
	logic [2:0]  base_q, base_d;
	logic [2:0]  node_q, node_d;
	logic [1:0]  chan_q, chan_d;
	logic        common_q, common_d;
	logic        query_q, query_d;
	logic        digit_q, digit_d;
	logic        swallow_q, swallow_d;
	logic        term_cr_q, term_cr_d;
	logic        line_empty_q, line_empty_d;
	sclp_cmd_t   cmd_q, cmd_d;
	logic        cmd_valid_q, cmd_valid_d;
	logic [7:0]  param_q, param_d;
	logic        param_valid_q, param_valid_d;
	logic [7:0]  err_q, err_d;
	logic [7:0]  resp_q, resp_d;
	logic        tx_resp_q, tx_resp_d;
	logic [2:0]  tx_idx_q, tx_idx_d;
	logic [7:0]  tx_char_q, tx_char_d;

	logic        kw_hit;
	logic [2:0]  kw_node;
	logic [2:0]  kw_leaf;
	logic        kw_chan_ok;
	logic        rx_fire;
	logic        is_term;
	logic        swallow_hit;
	logic        seg_ok;
	logic [3:0]  common_len;
	logic [7:0]  seg_err;
	logic [7:0]  bad;
	logic        err_set;
	logic        finish;
	logic        emit;
	logic        prompt;
	logic [2:0]  emit_node;
	logic [7:0]  c;
	logic [7:0]  up;

	function automatic logic [7:0] tx_char_f(input logic resp, input logic [2:0] idx, input logic [7:0] val);
		logic [7:0] ch;
		ch = SCLP_LF;
		if (!resp)
			ch = SCLP_PROMPT[3'(SCLP_PROMPT_LAST - idx)];
		else if (idx == 3'h0)
			ch = sclp_hex(val[7:4]);
		else if (idx == 3'h1)
			ch = sclp_hex(val[3:0]);
		else if (idx == 3'h2)
			ch = SCLP_CR;
		return ch;
	endfunction

	sclp_kw_match u_match (
		.kw_in       (kw_q),
		.len_in      (len_q),
		.level_in    (level_q),
		.hit_out     (kw_hit),
		.node_out    (kw_node),
		.leaf_out    (kw_leaf),
		.chan_ok_out (kw_chan_ok)
	);

	// framing and rate agreed outside this block
	assign c            = rx_char_in;
	assign up           = sclp_to_upper(rx_char_in);
	assign rx_fire      = rx_valid_in && (state_q != SCLP_ST_TX);
	assign is_term      = (c == SCLP_CR) || (c == SCLP_LF);
	// second half of CRLF or LFCR dropped
	assign swallow_hit  = swallow_q && ((term_cr_q && (c == SCLP_LF)) || (!term_cr_q && (c == SCLP_CR)));
	assign common_len   = 4'(len_q + 4'h1 + {3'h0, query_q});
	assign seg_ok       = common_q ? ((common_len == SCLP_COMMON_MIN) || (common_len == SCLP_COMMON_MAX))
		: (kw_hit && (!digit_q || kw_chan_ok));
	assign seg_err      = (common_q || kw_hit) ? SCLP_ERR_SYNTAX : SCLP_ERR_HEADER;

	assign rx_ready_out    = state_q != SCLP_ST_TX;
	assign tx_valid_out    = state_q == SCLP_ST_TX;
	assign tx_char_out     = tx_char_q;
	assign cmd_out         = cmd_q;
	assign cmd_valid_out   = cmd_valid_q;
	assign param_char_out  = param_q;
	assign param_valid_out = param_valid_q;
	assign err_code_out    = err_q;

	always_comb
	begin
		state_d = state_q;  kw_d = kw_q;  len_d = len_q;  level_d = level_q;  base_d = base_q;
		node_d = node_q;  chan_d = chan_q;  common_d = common_q;  query_d = query_q;  digit_d = digit_q;
		swallow_d = swallow_q;  term_cr_d = term_cr_q;  line_empty_d = line_empty_q;
		cmd_d = cmd_q;  cmd_valid_d = 1'b0;  param_d = param_q;  param_valid_d = 1'b0;
		resp_d = resp_q;  tx_resp_d = tx_resp_q;  tx_idx_d = tx_idx_q;  tx_char_d = tx_char_q;
		bad = SCLP_ERR_NONE;  finish = 1'b0;  emit = 1'b0;  prompt = 1'b0;  emit_node = node_q;
		if (state_q == SCLP_ST_TX)
		begin
			if (tx_ready_in)
			begin
				if (tx_idx_q == (tx_resp_q ? SCLP_RESP_LAST : SCLP_PROMPT_LAST))
					state_d = SCLP_ST_IDLE;
				else
				begin
					tx_idx_d  = tx_idx_q + 3'h1;
					tx_char_d = tx_char_f(tx_resp_q, tx_idx_d, resp_q);
				end
			end
		end
		else if (rx_fire)
		begin
			if (swallow_hit)
				swallow_d = 1'b0;
			else if (is_term)
			begin
				// CR or LF ends the line
				swallow_d    = 1'b1;
				term_cr_d    = c == SCLP_CR;
				line_empty_d = 1'b1;
				base_d       = SCLP_ROOT;
				state_d      = SCLP_ST_IDLE;
				if (state_q == SCLP_ST_HDR)
					finish = 1'b1;
				else if (state_q == SCLP_ST_PARAM)
					emit = 1'b1;
				else if ((state_q == SCLP_ST_IDLE) && line_empty_q)
					prompt = 1'b1;
			end
			else
			begin
				swallow_d = 1'b0;
				if (c != SCLP_SPACE)
					line_empty_d = 1'b0;
				unique case (state_q)
					SCLP_ST_IDLE:
					begin
						common_d = 1'b0;
						query_d  = 1'b0;
						digit_d  = 1'b0;
						// channel 1 unless a digit follows
						chan_d   = SCLP_CHAN_DEFAULT;
						len_d    = 4'h0;
						// stale letters would leak into the reported code
						kw_d     = '0;
						level_d  = base_q;
						if (c == SCLP_COLON)
						begin
							level_d = SCLP_ROOT;
							state_d = SCLP_ST_HDR;
						end
						else if (c == SCLP_STAR)
						begin
							common_d = 1'b1;
							state_d  = SCLP_ST_HDR;
						end
						else if (sclp_is_alpha(c))
						begin
							kw_d[SCLP_KW_MAX-1] = up;
							len_d               = 4'h1;
							state_d             = SCLP_ST_HDR;
						end
						else if ((c != SCLP_SPACE) && (c != SCLP_SEMI))
							bad = SCLP_ERR_SYNTAX;
					end
					SCLP_ST_HDR:
					begin
						if (c == SCLP_SPACE)
						begin
							if (seg_ok)
							begin
								node_d  = kw_leaf;
								state_d = SCLP_ST_PARAM;
							end
							else
								bad = seg_err;
						end
						else if (c == SCLP_SEMI)
						begin
							finish  = 1'b1;
							state_d = SCLP_ST_IDLE;
						end
						else if ((c == SCLP_QUERY) && !query_q)
							query_d = 1'b1;
						else if ((c == SCLP_COLON) && !common_q && !query_q && (len_q != 4'h0))
						begin
							if (seg_ok)
							begin
								level_d = kw_node;
								len_d   = 4'h0;
								digit_d = 1'b0;
								chan_d  = SCLP_CHAN_DEFAULT;
							end
							else
								bad = seg_err;
						end
						else if (sclp_is_alpha(c) && !query_q && !digit_q && (len_q < SCLP_KW_CAP))
						begin
							kw_d[SCLP_KW_MAX-1-int'(len_q)] = up;
							len_d                           = len_q + 4'h1;
						end
						else if (((c == SCLP_DIGIT1) || (c == SCLP_DIGIT2)) && !common_q && !query_q && !digit_q
							&& (len_q != 4'h0))
						begin
							digit_d = 1'b1;
							chan_d  = (c == SCLP_DIGIT1) ? SCLP_CHAN_DEFAULT : SCLP_CHAN_OTHER;
						end
						else
							bad = SCLP_ERR_SYNTAX;
					end
					SCLP_ST_PARAM:
					begin
						if (c == SCLP_SEMI)
						begin
							emit    = 1'b1;
							state_d = SCLP_ST_IDLE;
						end
						else
						begin
							param_d       = c;
							param_valid_d = 1'b1;
						end
					end
					SCLP_ST_SKIP:
					begin
						if (c == SCLP_SEMI)
							state_d = SCLP_ST_IDLE;
					end
					default:
						state_d = SCLP_ST_IDLE;
				endcase
			end
		end
		if (finish)
		begin
			if (seg_ok)
			begin
				emit      = 1'b1;
				emit_node = kw_leaf;
			end
			else
				bad = seg_err;
		end
		if ((bad != SCLP_ERR_NONE) && !is_term && (state_d != SCLP_ST_IDLE))
			state_d = SCLP_ST_SKIP;
		if (emit)
		begin
			cmd_d.common = common_q;
			cmd_d.query  = query_q;
			cmd_d.node   = common_q ? SCLP_ROOT : emit_node;
			cmd_d.chan   = chan_q;
			cmd_d.code   = kw_q[SCLP_KW_MAX-1 -: 4];
			cmd_valid_d  = 1'b1;
			if (!common_q && !is_term)
				base_d = level_q;
			if (query_q)
			begin
				resp_d    = resp_value_in;
				tx_resp_d = 1'b1;
				tx_idx_d  = 3'h0;
				tx_char_d = tx_char_f(1'b1, 3'h0, resp_value_in);
				state_d   = SCLP_ST_TX;
			end
		end
		if (prompt)
		begin
			tx_resp_d = 1'b0;
			tx_idx_d  = 3'h0;
			tx_char_d = tx_char_f(1'b0, 3'h0, resp_q);
			state_d   = SCLP_ST_TX;
		end
		err_set = bad != SCLP_ERR_NONE;
		if (err_set)
			err_d = bad;
		else if (err_clear_in)
			err_d = SCLP_ERR_NONE;
		else
			err_d = err_q;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_b_in)
		begin
			state_q <= SCLP_ST_IDLE;  kw_q <= '0;  len_q <= 4'h0;  level_q <= SCLP_ROOT;  base_q <= SCLP_ROOT;
			node_q <= SCLP_ROOT;  chan_q <= SCLP_CHAN_DEFAULT;  common_q <= 1'b0;  query_q <= 1'b0;
			digit_q <= 1'b0;  swallow_q <= 1'b0;  term_cr_q <= 1'b0;  line_empty_q <= 1'b1;
			cmd_q <= '0;  cmd_valid_q <= 1'b0;  param_q <= 8'h00;  param_valid_q <= 1'b0;
			err_q <= SCLP_ERR_NONE;  resp_q <= 8'h00;  tx_resp_q <= 1'b0;  tx_idx_q <= 3'h0;  tx_char_q <= 8'h00;
		end
		else
		begin
			state_q <= state_d;  kw_q <= kw_d;  len_q <= len_d;  level_q <= level_d;  base_q <= base_d;
			node_q <= node_d;  chan_q <= chan_d;  common_q <= common_d;  query_q <= query_d;
			digit_q <= digit_d;  swallow_q <= swallow_d;  term_cr_q <= term_cr_d;  line_empty_q <= line_empty_d;
			cmd_q <= cmd_d;  cmd_valid_q <= cmd_valid_d;  param_q <= param_d;  param_valid_q <= param_valid_d;
			err_q <= err_d;  resp_q <= resp_d;  tx_resp_q <= tx_resp_d;  tx_idx_q <= tx_idx_d;  tx_char_q <= tx_char_d;
		end
	end

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_b_in);

	prompt_on_empty_a: assert property (
		(rx_fire && is_term && !swallow_hit && (state_q == SCLP_ST_IDLE) && line_empty_q)
		|=> (tx_valid_out && !tx_resp_q && (tx_char_out == SCLP_PROMPT[SCLP_PROMPT_LAST])))
		else $error("no prompt after empty line");

	reply_crlf_a: assert property (
		(tx_valid_out && tx_ready_in && tx_resp_q && (tx_idx_q == 3'h2))
		|-> ((tx_char_out == SCLP_CR) ##1 (tx_valid_out && (tx_char_out == SCLP_LF))))
		else $error("reply line not ended by CR LF");

	pair_swallow_a: assert property (
		(rx_fire && swallow_hit) |=> (!cmd_valid_out && (state_q != SCLP_ST_TX)))
		else $error("second terminator of a pair acted on");

	default_chan_a: assert property (
		(cmd_valid_out && !cmd_out.common && !$past(digit_q)) |-> (cmd_out.chan == SCLP_CHAN_DEFAULT))
		else $error("channel not defaulted to 1");

	query_reply_a: assert property (
		(cmd_valid_out && cmd_out.query)
		|-> (tx_valid_out && tx_resp_q && (tx_char_out == sclp_hex($past(resp_value_in[7:4])))))
		else $error("query without reply");

	common_length_a: assert property (
		(cmd_valid_out && cmd_out.common)
		|-> ((($past(common_len)) == SCLP_COMMON_MIN) || ($past(common_len) == SCLP_COMMON_MAX)))
		else $error("common command of wrong length accepted");

	unknown_kw_a: assert property (
		(rx_fire && (state_q == SCLP_ST_HDR) && !common_q && !kw_hit && ((c == SCLP_SPACE) || (c == SCLP_SEMI)))
		|=> ((err_code_out == SCLP_ERR_HEADER) && !cmd_valid_out))
		else $error("unknown keyword not flagged");

	space_split_a: assert property (
		(rx_fire && (state_q == SCLP_ST_HDR) && (c == SCLP_SPACE) && seg_ok)
		|=> ((state_q == SCLP_ST_PARAM) && (node_q == $past(kw_leaf))))
		else $error("space did not start parameters");

	semi_level_a: assert property (
		(rx_fire && (state_q == SCLP_ST_PARAM) && (c == SCLP_SEMI) && !common_q)
		|=> ((base_q == $past(level_q)) && cmd_valid_out))
		else $error("chained command lost its level");

	case_fold_a: assert property (
		(rx_fire && (state_q == SCLP_ST_HDR) && sclp_is_lower(c) && !query_q && !digit_q && (len_q < SCLP_KW_CAP))
		|=> (kw_q[SCLP_KW_MAX-1-int'($past(len_q))] == ($past(rx_char_in) - 8'h20)))
		else $error("lower case letter not folded");

	err_set_wins_a: assert property (
		(err_set && err_clear_in) |=> (err_code_out != SCLP_ERR_NONE))
		else $error("clear beat a new error");
endmodule
`default_nettype wire

// ### dv/sclp_terminal.sv
// terminal model: offers command lines to the parser and collects its replies
`default_nettype none
module sclp_terminal
	import sclp_pkg::*;
(
	input  wire logic       core_clk_in,
	input  wire logic       rx_ready_in,
	input  wire logic [7:0] tx_char_in,
	input  wire logic       tx_valid_in,
	input  wire logic       slow_in,
	output logic [7:0]      rx_char_out,
	output logic            rx_valid_out,
	output logic            tx_ready_out,
	output logic            stuck_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] heard [$];

	initial
	begin
		rx_char_out = 8'h00;
		rx_valid_out = 1'b0;
		tx_ready_out = 1'b1;
		stuck_out = 1'b0;
	end

	// slow sink stalls every other cycle to stretch the reply
	always @(negedge core_clk_in)
		tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;

	always @(posedge core_clk_in)
		if (tx_valid_in === 1'b1 && tx_ready_out)
			heard.push_back(tx_char_in);

	task automatic send(input string s);
		int n;
		for (int i = 0; i < s.len(); i++)
		begin
			@(negedge core_clk_in);
			rx_char_out = s[i];
			rx_valid_out = 1'b1;
			n = 0;
			// ready only moves on a rising edge, so its value here stands at the next one
			while (rx_ready_in !== 1'b1 && n < 200)
			begin
				n++;
				@(negedge core_clk_in);
			end
			if (n >= 200)
				stuck_out = 1'b1;
			@(posedge core_clk_in);
		end
		@(negedge core_clk_in);
		rx_valid_out = 1'b0;
		// released line must not keep showing the last char
		rx_char_out = ~rx_char_out;
	endtask
endmodule
`default_nettype wire

// ### dv/serial_command_line_parser_bench.sv
// self-checking bench for the serial command line parser
`default_nettype none
module serial_command_line_parser_bench
	import sclp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       core_clk_in;
	logic       rst_b_in;
	logic [7:0] rx_char_in;
	logic       rx_valid_in;
	logic       rx_ready_out;
	logic [7:0] tx_char_out;
	logic       tx_valid_out;
	logic       tx_ready_in;
	sclp_cmd_t  cmd_out;
	logic       cmd_valid_out;
	logic [7:0] param_char_out;
	logic       param_valid_out;
	logic [7:0] resp_value_in;
	logic [7:0] err_code_out;
	logic       err_clear_in;
	logic       slow;
	logic       stuck;
	int         miscompares;
	int         total_checks;
	sclp_cmd_t  cmds [$];
	logic [7:0] params [$];

	sclp_parser u_sclp_parser (
		.core_clk_in     (core_clk_in),
		.rst_b_in        (rst_b_in),
		.rx_char_in      (rx_char_in),
		.rx_valid_in     (rx_valid_in),
		.rx_ready_out    (rx_ready_out),
		.tx_char_out     (tx_char_out),
		.tx_valid_out    (tx_valid_out),
		.tx_ready_in     (tx_ready_in),
		.cmd_out         (cmd_out),
		.cmd_valid_out   (cmd_valid_out),
		.param_char_out  (param_char_out),
		.param_valid_out (param_valid_out),
		.resp_value_in   (resp_value_in),
		.err_code_out    (err_code_out),
		.err_clear_in    (err_clear_in)
	);

	sclp_terminal u_sclp_terminal (
		.core_clk_in  (core_clk_in),
		.rx_ready_in  (rx_ready_out),
		.tx_char_in   (tx_char_out),
		.tx_valid_in  (tx_valid_out),
		.slow_in      (slow),
		.rx_char_out  (rx_char_in),
		.rx_valid_out (rx_valid_in),
		.tx_ready_out (tx_ready_in),
		.stuck_out    (stuck)
	);

	initial
	begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end

	always @(posedge core_clk_in)
	begin
		if (cmd_valid_out === 1'b1)
			cmds.push_back(cmd_out);
		if (param_valid_out === 1'b1)
			params.push_back(param_char_out);
	end

	task automatic test_done();
		if (miscompares == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// sends one line and waits, bounded, until the parser listens again
	task automatic run(input string s);
		int n;
		cmds.delete();
		params.delete();
		u_sclp_terminal.heard.delete();
		u_sclp_terminal.send(s);
		n = 0;
		repeat (2) @(negedge core_clk_in);
		while (rx_ready_out !== 1'b1 && n < 300)
		begin
			n++;
			@(negedge core_clk_in);
		end
		if (n >= 300 || stuck)
		begin
			miscompares++;
			test_done();
		end
	endtask

	task automatic chk_heard(input string e);
		chk(64'(u_sclp_terminal.heard.size()), 64'(e.len()));
		for (int i = 0; i < e.len() && i < u_sclp_terminal.heard.size(); i++)
			chk(64'(u_sclp_terminal.heard[i]), 64'(e[i]));
	endtask

	task automatic chk_cmd(input int i, input logic [2:0] node, input logic [1:0] chan);
		if (i >= cmds.size())
			chk(64'(cmds.size()), 64'(i + 1));
		else
			chk(64'({cmds[i].common, cmds[i].query, cmds[i].node, cmds[i].chan}), 64'({2'b00, node, chan}));
	endtask

	task automatic t_prompt();
		slow = 1'b1;
		run("\015");
		chk_heard("scpi > ");
		chk(64'(cmds.size()), 64'h0);
		slow = 1'b0;
	endtask

	task automatic t_common();
		run("*RST\015");
		chk(64'(cmds.size()), 64'h1);
		chk(64'({cmds[0].common, cmds[0].query, cmds[0].code}), 64'({2'b10, 32'h5253_5400}));
		chk_heard("");
		run("*AB\015");
		chk(64'(err_code_out), 64'(SCLP_ERR_SYNTAX));
		err_clear_in = 1'b1;
		@(negedge core_clk_in);
		err_clear_in = 1'b0;
		chk(64'(err_code_out), 64'h0);
	endtask

	task automatic t_query();
		resp_value_in = 8'hA5;
		slow = 1'b1;
		run("*IDN?\015");
		chk(64'({cmds[0].common, cmds[0].query}), 64'h3);
		chk_heard("A5\015\n");
		slow = 1'b0;
	endtask

	task automatic t_terms();
		run("*RST\n\015");
		chk(64'(cmds.size()), 64'h1);
		chk_heard("");
		run("*RST\015\015");
		chk(64'(cmds.size()), 64'h1);
		chk_heard("scpi > ");
	endtask

	task automatic t_forms();
		string forms [4] = '{"DIAG", "DIAGNOSTIC", "diag", "DiAgNoStIc"};
		foreach (forms[i])
		begin
			run({forms[i], "\015"});
			chk_cmd(0, 3'h6, 2'h1);
			chk(64'(err_code_out), 64'h0);
		end
	endtask

	task automatic t_trunc();
		run("DIAGN\015");
		chk(64'(cmds.size()), 64'h0);
		chk(64'(err_code_out), 64'(SCLP_ERR_HEADER));
		// clear held high: the error on ';' still lands first, then the next command runs
		err_clear_in = 1'b1;
		run("DIAGN;DIAG\015");
		err_clear_in = 1'b0;
		chk(64'(err_code_out), 64'h0);
		chk(64'(cmds.size()), 64'h1);
		chk(64'(cmds[0].node), 64'h6);
	endtask

	task automatic t_chan();
		run("OSC:RATE2;RATE;:DIAG\015");
		chk(64'(cmds.size()), 64'h3);
		chk_cmd(0, 3'h5, 2'h2);
		chk_cmd(1, 3'h5, 2'h1);
		chk(64'(cmds[2].node), 64'h6);
		run("sour:osc:rate1\015");
		chk_cmd(0, 3'h5, 2'h1);
	endtask

	task automatic t_implied();
		run("clock:time\015");
		chk(64'(cmds[0].node), 64'h3);
		chk(64'(err_code_out), 64'h0);
		run("CLOC\015");
		chk_cmd(0, 3'h3, 2'h1);
	endtask

	task automatic t_param();
		run("DIAG:LOG 7A;LOG 1\015");
		chk(64'(cmds[0].node), 64'h7);
		chk(64'(params.size()), 64'h3);
		chk(64'({params[0], params[1]}), 64'h3741);
		chk(64'(cmds.size()), 64'h2);
		chk(64'(cmds[1].node), 64'h7);
	endtask

	initial
	begin
		miscompares = 0;
		total_checks = 0;
		rst_b_in = 1'b0;
		resp_value_in = 8'h00;
		err_clear_in = 1'b0;
		slow = 1'b0;
		repeat (16) @(negedge core_clk_in);
		rst_b_in = 1'b1;
		chk(64'({tx_valid_out, err_code_out}), 64'h0);
		t_prompt();
		t_common();
		t_query();
		t_terms();
		t_forms();
		t_trunc();
		t_chan();
		t_implied();
		t_param();
		test_done();
	end
endmodule
`default_nettype wire
